// ---- bench/sfr_asserts.sv ----
// Purpose: Port checks of the flash read engine
// Assumes: Serial clock high and low at least 4 mclk
// Notes: Bound to the top module
module sfr_asserts (
  input logic mclk,
  input logic srst,
  input logic spi_clk_pin,
  input logic cs_n_pin,
  input logic [3:0] lane_out,
  input logic [3:0] lane_oe,
  input logic quad_lane_enable,
  input logic cont_mode_active,
  input logic wrap_disable,
  input logic [1:0] wrap_length_sel,
  input logic cmd_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // **********
  // Checks
  // **********
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  a_reset_outputs: assert property (disable iff (1'b0) srst |=>
    lane_oe == 4'h0 && !cont_mode_active && wrap_disable && wrap_length_sel == 2'h0 && !cmd_active)
    else $error("outputs not at reset value");
  a_frame_start: assert property ($fell(cs_n_pin) |-> ##[1:5] cmd_active)
    else $error("frame not seen");
  a_frame_end: assert property ($rose(cs_n_pin) |-> ##[1:5] (!cmd_active && lane_oe == 4'h0))
    else $error("frame not closed");
  a_lane_shape: assert property (lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad lane enable set");
  a_quad_gate: assert property ($rose(lane_oe[2]) |-> quad_lane_enable)
    else $error("quad output without enable");
  a_out_steady: assert property ((spi_clk_pin && lane_oe != 4'h0) [*4] |-> $stable(lane_out))
    else $error("output moved while clock high");
  a_cont_inframe: assert property ($changed(cont_mode_active) |-> $past(cmd_active))
    else $error("continuous state moved outside frame");
  a_wrap_inframe: assert property ($changed({wrap_disable, wrap_length_sel}) |-> $past(cmd_active))
    else $error("wrap bits moved outside frame");
endmodule
bind sfr_read_top sfr_asserts i_sfr_asserts (.mclk(mclk), .srst(srst), .spi_clk_pin(spi_clk_pin),
  .cs_n_pin(cs_n_pin), .lane_out(lane_out), .lane_oe(lane_oe), .quad_lane_enable(quad_lane_enable),
  .cont_mode_active(cont_mode_active), .wrap_disable(wrap_disable), .wrap_length_sel(wrap_length_sel),
  .cmd_active(cmd_active));

// ---- bench/sfr_host.sv ----
// Purpose: SPI host model for the flash read engine
// Assumes: mclk 4 ns, serial clock 32 ns, idle low
// Notes: Released lanes toggle every mclk
module sfr_host (
  input logic mclk,
  input logic [3:0] lane_out,
  input logic [3:0] lane_oe,
  output logic spi_clk_pin,
  output logic cs_n_pin,
  output logic [3:0] lane_in,
  output logic [7:0] rx_byte,
  output logic rx_vld
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] h_do = 4'h0;
  logic [3:0] h_oe = 4'h0;
  logic tog = 1'b0;
  // **********
  // Link
  // **********
  initial
  begin
    spi_clk_pin = 1'b0;
    cs_n_pin = 1'b1;
    rx_byte = 8'h00;
    rx_vld = 1'b0;
  end
  always @(negedge mclk) tog <= ~tog;
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & h_oe & h_do) | (~lane_oe & ~h_oe & {2{tog, ~tog}});
  task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s);
    h_do = v;
    h_oe = oe;
    repeat (4) @(negedge mclk);
    spi_clk_pin = 1'b1;
    repeat (3) @(negedge mclk);
    s = lane_in;
    @(negedge mclk);
    spi_clk_pin = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] s;
    for (int k = n - w; k >= 0; k -= w)
      tick(4'((v >> k) & ((1 << w) - 1)), 4'((1 << w) - 1), s);
  endtask
  task automatic idle(input int n);
    logic [3:0] s;
    repeat (n) tick(4'h0, 4'h0, s);
  endtask
  task automatic recv(input int w, input int n);
    logic [3:0] s;
    logic [7:0] b;
    logic on;
    repeat (n)
    begin
      b = 8'h00;
      on = 1'b0;
      for (int k = 0; k < 8 / w; k++)
      begin
        tick(4'h0, 4'h0, s);
        on |= |lane_oe;
        b = 8'((b << w) | (w == 1 ? 4'(s[1]) : s & 4'((1 << w) - 1)));
      end
      if (on)
      begin
        rx_byte = b;
        rx_vld = 1'b1;
        @(negedge mclk);
        rx_vld = 1'b0;
      end
    end
  endtask
  task automatic start();
    cs_n_pin = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic stop();
    cs_n_pin = 1'b1;
    h_oe = 4'h0;
    repeat (24) @(negedge mclk);
  endtask
endmodule

// ---- bench/sfr_read_top_tb.sv ----
// Purpose: Self-checking bench of the flash read engine
// Assumes: Host model drives the link, bench loads the array
// Notes: Expected bytes queued by the driver, checked on arrival
module sfr_read_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic busy = 1'b0;
  logic qe = 1'b0;
  logic we = 1'b0;
  logic [11:0] wa = 12'h000;
  logic [7:0] wd = 8'h00;
  wire sclk, csn, vld, cont, wdis, act;
  wire [3:0] li, lo, loe;
  wire [1:0] wsel;
  wire [7:0] rxb;
  logic [7:0] mem [0:4095];
  logic [7:0] q [$];
  logic [23:0] a;
  logic wdis_e = 1'b1;
  logic [1:0] wsel_e = 2'h0;
  int fail_count = 0;
  int num_checks = 0;
  initial forever #2 mclk = ~mclk;
  sfr_read_top #(.MEM_AW(12)) i_sfr_read_top (.mclk(mclk), .srst(srst), .spi_clk_pin(sclk), .cs_n_pin(csn),
    .lane_in(li), .lane_out(lo), .lane_oe(loe), .busy(busy), .quad_lane_enable(qe), .mem_wr_en(we),
    .mem_wr_addr(wa), .mem_wr_data(wd), .cont_mode_active(cont), .wrap_disable(wdis),
    .wrap_length_sel(wsel), .cmd_active(act));
  sfr_host i_sfr_host (.mclk(mclk), .lane_out(lo), .lane_oe(loe), .spi_clk_pin(sclk), .cs_n_pin(csn),
    .lane_in(li), .rx_byte(rxb), .rx_vld(vld));
  // **********
  // Checking
  // **********
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk)
    if (vld)
      if (q.size() == 0)
        chk(1, 0);
      else
        chk(rxb, q.pop_front());
  function automatic logic [23:0] ra();
    return 24'($urandom) & 24'hFFFFFE;
  endfunction
  task automatic rd(input logic [7:0] op, input logic [23:0] ad, input int aw, input int mv, input int dm,
    input int dw, input int n, input bit ok);
    logic [23:0] p;
    logic [7:0] m;
    p = ad;
    m = 8'((8 << wsel_e) - 1);
    repeat (n)
    begin
      if (ok)
        q.push_back(mem[p[11:0]]);
      if ((op == 8'hEB || (op == 8'h00 && aw == 4)) && !wdis_e)
        p[7:0] = (p[7:0] & ~m) | ((p[7:0] + 8'h01) & m);
      else
        p = p + 24'h1;
    end
    i_sfr_host.start();
    if (op != 8'h00)
      i_sfr_host.send(op, 8, 1);
    i_sfr_host.send(ad, 24, aw);
    if (mv >= 0)
      i_sfr_host.send(mv, 8, aw);
    i_sfr_host.idle(dm);
    i_sfr_host.recv(dw, n);
    i_sfr_host.stop();
    chk(q.size(), 0);
  endtask
  task automatic setw(input logic [7:0] w);
    i_sfr_host.start();
    i_sfr_host.send(8'h77, 8, 1);
    i_sfr_host.idle(6);
    i_sfr_host.send(w, 8, 4);
    i_sfr_host.stop();
    if (qe && !busy)
    begin
      wdis_e = w[4];
      wsel_e = w[6:5];
    end
  endtask
  // **********
  // Tests
  // **********
  initial
  begin
    void'($urandom(82915));
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    chk({wdis, wsel, cont, loe}, 8'h80);
    for (int i = 0; i < 4096; i++)
    begin
      mem[i] = 8'($urandom);
      wa = 12'(i);
      wd = mem[i];
      we = 1'b1;
      @(negedge mclk);
    end
    we = 1'b0;
    rd(8'h03, 24'hFFFFFE, 1, -1, 0, 1, 3, 1);
    rd(8'h0B, ra(), 1, -1, 8, 1, 2, 1);
    rd(8'h3B, ra(), 1, -1, 8, 2, 2, 1);
    busy = 1'b1;
    rd(8'h03, ra(), 1, -1, 0, 1, 2, 0);
    busy = 1'b0;
    rd(8'h5A, ra(), 1, -1, 0, 1, 1, 0);
    rd(8'h6B, ra(), 1, -1, 8, 4, 2, 0);
    rd(8'hEB, ra(), 4, 0, 4, 4, 2, 0);
    setw(8'h00);
    chk(wdis, 1'b1);
    qe = 1'b1;
    rd(8'h6B, ra(), 1, -1, 8, 4, 2, 1);
    rd(8'hBB, ra(), 2, 8'hA5, 0, 2, 2, 1);
    chk(cont, 1'b1);
    rd(8'h00, ra(), 2, 8'h2A, 0, 2, 2, 1);
    rd(8'h00, 24'h555555, 2, 8'h55, 0, 2, 0, 1);
    chk(cont, 1'b0);
    rd(8'hBB, ra(), 2, 8'h00, 0, 2, 1, 1);
    rd(8'hEB, ra(), 4, 8'h2F, 4, 4, 2, 1);
    chk(cont, 1'b1);
    rd(8'h00, ra(), 4, 8'hE0, 4, 4, 2, 1);
    rd(8'h00, 24'h111111, 4, 8'h11, 4, 4, 0, 1);
    chk(cont, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      setw(8'(s << 5));
      chk({wdis, wsel}, 3'(s));
      a = (ra() & ~24'((8 << s) - 1)) | 24'((8 << s) - 2);
      rd(8'hEB, a, 4, 8'h00, 4, 4, 4, 1);
    end
    setw(8'h10);
    chk({wdis, wsel}, 3'h4);
    rd(8'hEB, 24'h0000FE, 4, 8'h00, 4, 4, 3, 1);
    rd(8'hBB, ra(), 2, 8'h20, 0, 2, 1, 1);
    srst = 1'b1;
    wdis_e = 1'b1;
    wsel_e = 2'h0;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    chk({cont, wdis}, 2'h1);
    repeat (4) @(negedge mclk);
    rd(8'h03, ra(), 1, -1, 0, 1, 1, 1);
    print_verdict();
  end
  initial
  begin
    #200us;
    fail_count++;
    print_verdict();
  end
endmodule

// ---- hdl/sfr_read_top.v ----
// Purpose: Read command engine of a serial NOR flash, device side
// Assumes: Host makes the serial clock much slower than mclk
// Notes: Serial clock, chip select and lanes are sampled by mclk
//
// How it works
// (R01) Opcode 03h then 24-bit address, rising edge
// (R02) Byte driven MSB first on falling edges
// (R03) Address advances per byte; chip select ends
// (R04) Reads ignored while busy is set; code checks busy only at opcode end, so continuous frames skip it
// (R05) Opcode accepted only on single lane
// (R06) Fast read waits eight dummy clocks
// (R07) Dual output after eight dummy clocks
// (R08) Quad output read needs quad lane enable
// (R09) Quad output on four lanes after dummies
// (R10) Dual I/O address two bits per clock
// (R11) Only mode bits 5:4 matter
// (R12) Mode 10 skips dual opcode next frame
// (R13) Other mode values need an opcode again
// (R14) Host sends FFFFh to leave dual mode
// (R15) Host never sends dual address ending 11
// (R16) Quad I/O: four lanes, four dummy clocks
// (R17) Quad I/O needs quad lane enable; code checks it only at opcode end, not in continuous frames
// (R18) Mode 10 skips quad opcode next frame
// (R19) Host sends FFh to leave quad mode
// (R20) Quad I/O read wraps within section
// (R21) Burst setup holds three wrap bits
// (R22) Wrap lengths 8 to 64, disabled at reset
// (R23) Dual data: odd bits on lane one
// (R24) Quad data: high nibble first
// (R25) Quad address nibble per clock, MSB first
// (R26) Dual mode byte four clocks, no dummies
// (R27) Continuous state kept, cleared at reset
`include "sfr_consts.vh"

module sfr_read_top #(
  parameter MEM_AW = 12
)
(
  input wire mclk,
  input wire srst,
  input wire spi_clk_pin,
  input wire cs_n_pin,
  input wire [3:0] lane_in,
  output wire [3:0] lane_out,
  output wire [3:0] lane_oe,
  input wire busy,
  input wire quad_lane_enable,
  input wire mem_wr_en,
  input wire [MEM_AW-1:0] mem_wr_addr,
  input wire [7:0] mem_wr_data,
  output wire cont_mode_active,
  output wire wrap_disable,
  output wire [1:0] wrap_length_sel,
  output wire cmd_active
);

  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_CMD = 8'h02;
  localparam [7:0] ST_ADDR = 8'h04;
  localparam [7:0] ST_MODE = 8'h08;
  localparam [7:0] ST_DUMMY = 8'h10;
  localparam [7:0] ST_DATA = 8'h20;
  localparam [7:0] ST_IGNORE = 8'h40;
  localparam [7:0] ST_SPARE = 8'h80;

  reg [7:0] mem [0:(1<<MEM_AW)-1];
  reg [7:0] st_ff;
  reg [5:0] cnt_ff;
  reg [5:0] dum_ff;
  reg [1:0] lw_ff;
  reg [7:0] cmd_ff;
  reg [23:0] shift_ff;
  reg [23:0] rd_addr_ff;
  reg [7:0] sh_ff;
  reg [5:0] beat_ff;
  reg clk_d_ff;
  reg cont_ff;
  reg cont_quad_ff;
  reg wrap_dis_ff;
  reg [1:0] wrap_len_ff;
  reg [3:0] out_ff;
  reg [3:0] oe_ff;
  reg act_ff;

  wire clk_s;
  wire cs_n_s;
  wire [3:0] lane_s;
  wire rise;
  wire fall;
  wire [23:0] shift_nxt;
  wire [5:0] addr_clks;
  wire [5:0] byte_clks;
  wire [7:0] cur_byte;
  wire [7:0] wrap_mask;
  wire [23:0] nxt_rd_addr;
  reg [3:0] nxt_out;
  reg [7:0] nxt_sh;
  reg cs_n_d_ff;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  sfr_sync #(
    .W(6),
    .RST_VAL(6'h02)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .din({lane_in, cs_n_pin, spi_clk_pin}),
    .dout({lane_s, cs_n_s, clk_s})
  );

  // ************************************************************
  // Edge detection and shared helpers
  // ************************************************************
  always @(posedge mclk)
  begin
    if (srst)
    begin
      clk_d_ff <= 1'h0;
      cs_n_d_ff <= 1'h1;
    end
    else
    begin
      clk_d_ff <= clk_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  // (R01) Sample on rising edge
  assign rise = clk_s & ~clk_d_ff & ~cs_n_s;
  // (R02) Drive on falling edge
  assign fall = ~clk_s & clk_d_ff & ~cs_n_s;

  // (R25) Lane shift order
  assign shift_nxt = (lw_ff == `SFR_LW_ONE) ? {shift_ff[22:0], lane_s[0]} :
                     (lw_ff == `SFR_LW_TWO) ? {shift_ff[21:0], lane_s[1:0]} :
                     {shift_ff[19:0], lane_s};

  assign addr_clks = `SFR_ADDR_BITS >> lw_ff;
  assign byte_clks = `SFR_BYTE_BITS >> lw_ff;

  // (R03) Byte source per beat
  assign cur_byte = (beat_ff == 6'h00) ? mem[rd_addr_ff[MEM_AW-1:0]] : sh_ff;

  // (R22) Section mask from length
  assign wrap_mask = (`SFR_WRAP_BASE << wrap_len_ff) - 8'h01;

  // (R20) Wrap inside section
  assign nxt_rd_addr = (cmd_ff == `SFR_OP_QUAD_IO && !wrap_dis_ff) ?
                       ((rd_addr_ff & ~{16'h0000, wrap_mask}) |
                        ((rd_addr_ff + 24'h000001) & {16'h0000, wrap_mask})) :
                       (rd_addr_ff + 24'h000001);

  // ************************************************************
  // Output lane mapping
  // ************************************************************
  always @*
  begin
    nxt_out = 4'h0;
    nxt_sh = 8'h00;
    case (lw_ff)
      `SFR_LW_ONE:
      begin
        nxt_out[1] = cur_byte[7];
        nxt_sh = {cur_byte[6:0], 1'h0};
      end
      `SFR_LW_TWO:
      begin
        // (R23) Odd bits on lane one
        nxt_out[1:0] = cur_byte[7:6];
        nxt_sh = {cur_byte[5:0], 2'h0};
      end
      default:
      begin
        // (R24) High nibble first
        nxt_out = cur_byte[7:4];
        nxt_sh = {cur_byte[3:0], 4'h0};
      end
    endcase
  end

  // ************************************************************
  // Backing memory
  // ************************************************************
  always @(posedge mclk)
  begin
    if (mem_wr_en)
    begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end

  // ************************************************************
  // Command sequencer
  // ************************************************************
  always @(posedge mclk)
  begin
    if (srst)
    begin
      st_ff <= ST_IDLE;
      cnt_ff <= 6'h00;
      dum_ff <= 6'h00;
      lw_ff <= `SFR_LW_ONE;
      cmd_ff <= 8'h00;
      shift_ff <= 24'h000000;
      rd_addr_ff <= 24'h000000;
      sh_ff <= 8'h00;
      beat_ff <= 6'h00;
      // (R27) Continuous state cleared
      cont_ff <= 1'h0;
      cont_quad_ff <= 1'h0;
      // (R22) Wrap off at reset
      wrap_dis_ff <= `SFR_WRAP_DIS_RST;
      wrap_len_ff <= `SFR_WRAP_LEN_RST;
      out_ff <= 4'h0;
      oe_ff <= 4'h0;
      act_ff <= 1'h0;
    end
    else if (cs_n_s)
    begin
      // (R03) Chip select high ends command
      st_ff <= ST_IDLE;
      oe_ff <= 4'h0;
      act_ff <= 1'h0;
    end
    else if (cs_n_d_ff)
    begin
      cnt_ff <= 6'h00;
      shift_ff <= 24'h000000;
      beat_ff <= 6'h00;
      act_ff <= 1'h1;
      if (cont_ff)
      begin
        // (R12) Dual frame opens with address
        // (R18) Quad frame opens with address
        st_ff <= ST_ADDR;
        lw_ff <= cont_quad_ff ? `SFR_LW_FOUR : `SFR_LW_TWO;
        cmd_ff <= cont_quad_ff ? `SFR_OP_QUAD_IO : `SFR_OP_DUAL_IO;
        dum_ff <= `SFR_DUMMY_QIO;
      end
      else
      begin
        // (R05) Opcode on single lane
        st_ff <= ST_CMD;
        lw_ff <= `SFR_LW_ONE;
      end
    end
    else
    begin
      case (st_ff)
        ST_CMD:
        begin
          if (rise)
          begin
            shift_ff <= shift_nxt;
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == `SFR_OP_BITS - 6'h01)
            begin
              cnt_ff <= 6'h00;
              cmd_ff <= shift_nxt[7:0];
              st_ff <= ST_ADDR;
              dum_ff <= `SFR_DUMMY_FAST;
              lw_ff <= `SFR_LW_ONE;
              case (shift_nxt[7:0])
                `SFR_OP_READ:
                begin
                  dum_ff <= 6'h00;
                end
                `SFR_OP_FAST, `SFR_OP_DUAL_OUT:
                begin
                  dum_ff <= `SFR_DUMMY_FAST;
                end
                `SFR_OP_QUAD_OUT:
                begin
                  // (R08) Needs quad lane enable
                  if (!quad_lane_enable)
                  begin
                    st_ff <= ST_IGNORE;
                  end
                end
                `SFR_OP_DUAL_IO:
                begin
                  // (R10) Two-lane address
                  lw_ff <= `SFR_LW_TWO;
                end
                `SFR_OP_QUAD_IO, `SFR_OP_WRAP_SET:
                begin
                  // (R17) Needs quad lane enable
                  lw_ff <= `SFR_LW_FOUR;
                  dum_ff <= `SFR_DUMMY_QIO;
                  if (!quad_lane_enable)
                  begin
                    st_ff <= ST_IGNORE;
                  end
                end
                default:
                begin
                  st_ff <= ST_IGNORE;
                end
              endcase
              // (R04) Busy blocks reads
              if (busy)
              begin
                st_ff <= ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR:
        begin
          if (rise)
          begin
            shift_ff <= shift_nxt;
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == addr_clks - 6'h01)
            begin
              cnt_ff <= 6'h00;
              rd_addr_ff <= shift_nxt;
              beat_ff <= 6'h00;
              if (cmd_ff == `SFR_OP_DUAL_IO || cmd_ff == `SFR_OP_QUAD_IO ||
                  cmd_ff == `SFR_OP_WRAP_SET)
              begin
                st_ff <= ST_MODE;
              end
              else if (cmd_ff == `SFR_OP_READ)
              begin
                // (R02) Data right after address
                st_ff <= ST_DATA;
              end
              else
              begin
                // (R06) Eight dummy clocks
                st_ff <= ST_DUMMY;
              end
            end
          end
        end
        ST_MODE:
        begin
          if (rise)
          begin
            shift_ff <= shift_nxt;
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == byte_clks - 6'h01)
            begin
              cnt_ff <= 6'h00;
              if (cmd_ff == `SFR_OP_WRAP_SET)
              begin
                // (R21) Hold wrap bits
                wrap_dis_ff <= shift_nxt[`SFR_WRAP_DIS_BIT];
                wrap_len_ff <= shift_nxt[`SFR_WRAP_LEN_HI:`SFR_WRAP_LEN_LO];
                st_ff <= ST_IGNORE;
              end
              else
              begin
                // (R11) Mode bits 5:4 only
                // (R13) Other values clear mode
                cont_ff <= (shift_nxt[`SFR_MODE_SEL_HI:`SFR_MODE_SEL_LO] == `SFR_CONT_KEY);
                cont_quad_ff <= (lw_ff == `SFR_LW_FOUR);
                // (R26) Dual goes straight to data
                // (R16) Quad waits four dummies
                st_ff <= (lw_ff == `SFR_LW_FOUR) ? ST_DUMMY : ST_DATA;
              end
            end
          end
        end
        ST_DUMMY:
        begin
          if (rise)
          begin
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == dum_ff - 6'h01)
            begin
              cnt_ff <= 6'h00;
              st_ff <= ST_DATA;
              // (R07) Dual output lanes
              if (cmd_ff == `SFR_OP_DUAL_OUT)
              begin
                lw_ff <= `SFR_LW_TWO;
              end
              // (R09) Quad output lanes
              else if (cmd_ff == `SFR_OP_QUAD_OUT)
              begin
                lw_ff <= `SFR_LW_FOUR;
              end
            end
          end
        end
        ST_DATA:
        begin
          if (fall)
          begin
            // (R02) Shift out on falling edge
            out_ff <= nxt_out;
            sh_ff <= nxt_sh;
            oe_ff <= (lw_ff == `SFR_LW_ONE) ? 4'h2 :
                     (lw_ff == `SFR_LW_TWO) ? 4'h3 : 4'hF;
            if (beat_ff == 6'h00)
            begin
              // (R03) Advance address per byte
              rd_addr_ff <= nxt_rd_addr;
            end
            beat_ff <= (beat_ff == byte_clks - 6'h01) ? 6'h00 : beat_ff + 6'h01;
          end
        end
        default:
        begin
          oe_ff <= 4'h0;
        end
      endcase
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign lane_out = out_ff;
  assign lane_oe = oe_ff;
  assign cont_mode_active = cont_ff;
  assign wrap_disable = wrap_dis_ff;
  assign wrap_length_sel = wrap_len_ff;
  assign cmd_active = act_ff;

endmodule

// ---- hdl/sfr_sync.v ----
// Purpose: Two-flop synchroniser for pins from outside mclk
// Assumes: Inputs are asynchronous levels
// Notes: First stage is read only by the second stage
`include "sfr_consts.vh"

module sfr_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
  input wire mclk,
  input wire srst,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // ************************************************************
  // Synchroniser stages
  // ************************************************************
  always @(posedge mclk)
  begin
    if (srst)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// ---- shared/sfr_consts.vh ----
// Purpose: Constants of the serial flash read command block
// Assumes: Included by the design files of this block only
// Notes: Opcodes, field positions, counts and reset values
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH

// ************************************************************
// Opcodes
// ************************************************************
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DUAL_OUT 8'h3B
`define SFR_OP_QUAD_OUT 8'h6B
`define SFR_OP_DUAL_IO 8'hBB
`define SFR_OP_QUAD_IO 8'hEB
`define SFR_OP_WRAP_SET 8'h77

// ************************************************************
// Lane width codes (log2 of lanes)
// ************************************************************
`define SFR_LW_ONE 2'h0
`define SFR_LW_TWO 2'h1
`define SFR_LW_FOUR 2'h2

// ************************************************************
// Phase lengths in bits and clocks
// ************************************************************
`define SFR_OP_BITS 6'h08
`define SFR_ADDR_BITS 6'h18
`define SFR_BYTE_BITS 6'h08
`define SFR_DUMMY_FAST 6'h08
`define SFR_DUMMY_QIO 6'h04

// ************************************************************
// Mode and wrap fields
// ************************************************************
`define SFR_CONT_KEY 2'h2
`define SFR_MODE_SEL_HI 5
`define SFR_MODE_SEL_LO 4
`define SFR_WRAP_DIS_BIT 4
`define SFR_WRAP_LEN_HI 6
`define SFR_WRAP_LEN_LO 5
`define SFR_WRAP_DIS_RST 1'h1
`define SFR_WRAP_LEN_RST 2'h0
`define SFR_WRAP_BASE 8'h08

`endif
